/* File: vcmb_defs.vh */
`ifndef VCMB_DEFS_VH
`define VCMB_DEFS_VH

// opcodes handled by this block
`define VCMB_OP_JUF0C      8'h86
`define VCMB_OP_JUF1C      8'h66
`define VCMB_OP_JTFC       8'h06
`define VCMB_OP_JTFS       8'h16
`define VCMB_OP_JXLO       8'hA6
`define VCMB_OP_JXHI       8'hB6
`define VCMB_OP_JAZ        8'hC6
`define VCMB_OP_JANZ       8'hD6
`define VCMB_OP_LD_IMM     8'h23
`define VCMB_OP_RD_TPP     8'h9B
`define VCMB_OP_RD_ORG     8'h9A
`define VCMB_OP_RD_UPPER   8'hE2
`define VCMB_OP_WR_UPPER   8'hC2
`define VCMB_OP_RD_HORIZONTAL_LIGHTPEN_LATCH    8'h3F
`define VCMB_OP_RD_VERTICAL_LIGHTPEN_LATCH    8'h3E
`define VCMB_OP_RD_INTREG  8'h8C
`define VCMB_OP_RD_STATW   8'hC7
`define VCMB_OP_WR_STATW   8'hD7
`define VCMB_OP_RD_UCOND   8'h9C
`define VCMB_OP_RD_TIMER   8'h42
`define VCMB_OP_WR_TIMER   8'h62
`define VCMB_OP_WR_IEN     8'h82
`define VCMB_OP_WR_START   8'h0D
`define VCMB_OP_WR_LAST    8'h0C
`define VCMB_OP_WR_SLINE   8'h0E
`define VCMB_OP_WR_ORG     8'h8A
`define VCMB_OP_WR_TPP     8'h8B
`define VCMB_OP_WR_PRESC   8'h22
`define VCMB_OP_WR_RATE    8'h02
`define VCMB_OP_WR_UCTL    8'h01
`define VCMB_OP_WR_UMUX    8'h33
`define VCMB_OP_WR_TCIDX   8'h87
`define VCMB_OP_WR_TCIND   8'hB7
`define VCMB_OP_PAIR_A_R0  8'h98
`define VCMB_OP_PAIR_A_R1  8'h99
`define VCMB_OP_PAIR_R0_A  8'h88
`define VCMB_OP_PAIR_R1_A  8'h89
`define VCMB_OP_TBL_PAGE   8'hB3
`define VCMB_OP_TBL_PAGE3  8'hF3
`define VCMB_OP_DM_RD_TPP  8'h9D
`define VCMB_OP_DM_RD_R0   8'h90
`define VCMB_OP_DM_RD_R1   8'h91
`define VCMB_OP_DM_WR_TPP  8'h8D
`define VCMB_OP_DM_WR_R0   8'h80
`define VCMB_OP_DM_WR_R1   8'h81

// program counter layout and timing chain depth
`define VCMB_PC_W          13
`define VCMB_PAGE3_BITS    3'h3
`define VCMB_TC_DEPTH      16

// register port map (word index on reg_addr)
`define VCMB_RA_CTRL       5'h00
`define VCMB_RA_STATUS     5'h01
`define VCMB_RA_PC_LO      5'h02
`define VCMB_RA_PC_HI      5'h03
`define VCMB_RA_ACC        5'h04
`define VCMB_RA_UPPER      5'h05
`define VCMB_RA_R0         5'h06
`define VCMB_RA_R1         5'h07
`define VCMB_RA_RA         5'h08
`define VCMB_RA_RB         5'h09
`define VCMB_RA_TC_BASE    1'h1
`define VCMB_CTRL_RESET    3'h0
`define VCMB_CTRL_RUN      0
`define VCMB_CTRL_UF0      1
`define VCMB_CTRL_UF1      2

`endif

/* File: vcmb_move_branch.v */
// What this block does
// - user-flag-clear jumps branch in page, else skip two
// - timer-clear jump branches; fall-through clears timer flag
// - timer-set jump branches and clears flag
// - pin jumps test external pin low or high
// - zero jumps test accumulator zero or nonzero
// - text pointer read fills upper/low pair, flag
// - horizontal pen read, bit seven zero
// - vertical pen read, bits five-seven zero
// - uart condition read, bits six-seven one
// - interrupt register read into accumulator, one cycle
// - accumulator written into interrupt enable bits
// - low to upper and upper to low copies
// - sixteen-bit video address registers loaded from pair
// - indexed timing chain write then index increments
// - status word write replaces all eight bits
// - in-page table fetch, then old counter plus one
// - page-three table fetch forces counter bits 011
// - display memory read into pair, two cycles minimum
// - display memory write from pair, two cycles minimum
// - timer read and written as eight bits
// - uart setup registers written from accumulator
// - immediate load takes second byte, two cycles
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "vcmb_defs.vh"

module vcmb_move_branch (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire [4:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	output reg  [12:0] pm_addr,
	input  wire [7:0]  pm_data,
	output reg         dm_req,
	output reg         dm_we,
	output reg  [15:0] dm_addr,
	output reg  [15:0] dm_wdata,
	input  wire [15:0] dm_rdata,
	input  wire        dm_ack,
	input  wire        external_interrupt_pin,
	input  wire        timer_event,
	input  wire [6:0]  horizontal_lightpen_latch,
	input  wire [4:0]  vertical_lightpen_latch,
	input  wire [5:0]  uart_condition_latch,
	input  wire [7:0]  interrupt_register,
	output reg  [12:0] pc,
	output reg  [7:0]  acc,
	output reg  [7:0]  upper_accumulator,
	output reg         upper_acc_flag,
	output reg         timer_flag,
	output reg  [7:0]  timer_value,
	output reg  [7:0]  program_status_word,
	output reg  [7:0]  interrupt_enable,
	output reg  [15:0] display_ram_start,
	output reg  [15:0] display_ram_last,
	output reg  [15:0] status_line_address,
	output reg  [15:0] screen_origin,
	output reg  [15:0] text_position_pointer,
	output reg  [7:0]  uart_prescaler,
	output reg  [7:0]  bit_rate_select,
	output reg  [7:0]  uart_control,
	output reg  [7:0]  uart_multiplex,
	output reg  [7:0]  timing_chain_index
);

	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_EXEC  = 5'h02;
	localparam [4:0] ST_OPER  = 5'h04;
	localparam [4:0] ST_TABLE = 5'h08;
	localparam [4:0] ST_DMEM  = 5'h10;

	reg [4:0]  state;
	reg [7:0]  cur_op;
	reg        take;
	reg        run;
	reg        user_flag_zero;
	reg        user_flag_one;
	reg [7:0]  r0;
	reg [7:0]  r1;
	reg [7:0]  upper_byte_for_r0;
	reg [7:0]  upper_byte_for_r1;
	reg [7:0]  tc_q [0:`VCMB_TC_DEPTH-1];

	wire [7:0]  op       = pm_data;
	wire        in_exec  = (state == ST_EXEC);
	wire [12:0] pc_one   = pc + 13'h0001;
	wire [12:0] pc_two   = pc + 13'h0002;
	wire [15:0] acc_pair = {upper_accumulator, acc};

	////////////////////////////////////////////////////////////////////////
	// jump decode
	// condition is taken in the opcode cycle; the operand
	// cycle only picks the target or the skip

	reg is_jump;
	reg jump_cond;
	always @* begin
		is_jump   = 1'b1;
		jump_cond = 1'b0;
		case (op)
			`VCMB_OP_JUF0C: jump_cond = ~user_flag_zero;
			`VCMB_OP_JUF1C: jump_cond = ~user_flag_one;
			`VCMB_OP_JTFC:  jump_cond = ~timer_flag;
			`VCMB_OP_JTFS:  jump_cond = timer_flag;
			`VCMB_OP_JXLO:  jump_cond = ~external_interrupt_pin;
			`VCMB_OP_JXHI:  jump_cond = external_interrupt_pin;
			`VCMB_OP_JAZ:   jump_cond = (acc == 8'h00);
			`VCMB_OP_JANZ:  jump_cond = (acc != 8'h00);
			default:        is_jump = 1'b0;
		endcase
	end

	// timer flag is cleared by the not-taken timer-clear jump or taken timer-set jump
	wire tf_clear = in_exec &&
		((op == `VCMB_OP_JTFC && timer_flag) ||
		 (op == `VCMB_OP_JTFS && timer_flag));

	// the six display-memory transfer opcodes
	wire dm_start = (op == `VCMB_OP_DM_RD_TPP) || (op == `VCMB_OP_DM_RD_R0) ||
		(op == `VCMB_OP_DM_RD_R1) || (op == `VCMB_OP_DM_WR_TPP) ||
		(op == `VCMB_OP_DM_WR_R0) || (op == `VCMB_OP_DM_WR_R1);
	wire dm_write = (op == `VCMB_OP_DM_WR_TPP) || (op == `VCMB_OP_DM_WR_R0) ||
		(op == `VCMB_OP_DM_WR_R1);

	// display pointer: text position or the addressed register pair
	reg [15:0] dm_target;
	always @* begin
		case (op)
			`VCMB_OP_DM_RD_R0, `VCMB_OP_DM_WR_R0: dm_target = {upper_byte_for_r0, r0};
			`VCMB_OP_DM_RD_R1, `VCMB_OP_DM_WR_R1: dm_target = {upper_byte_for_r1, r1};
			default:                              dm_target = text_position_pointer;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// timer flag: a new event wins over a clear

	always @(posedge mclk) begin
		if (!rst_n)
			timer_flag <= 1'b0;
		else
			timer_flag <= timer_event | (timer_flag & ~tf_clear);
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer and accumulator moves

	always @(posedge mclk) begin
		if (!rst_n) begin
			state                 <= ST_IDLE;
			cur_op                <= 8'h00;
			take                  <= 1'b0;
			pc                    <= 13'h0000;
			pm_addr               <= 13'h0000;
			acc                   <= 8'h00;
			upper_accumulator     <= 8'h00;
			upper_acc_flag        <= 1'b0;
			timer_value           <= 8'h00;
			program_status_word   <= 8'h00;
			interrupt_enable      <= 8'h00;
			display_ram_start     <= 16'h0000;
			display_ram_last      <= 16'h0000;
			status_line_address   <= 16'h0000;
			screen_origin         <= 16'h0000;
			text_position_pointer <= 16'h0000;
			uart_prescaler        <= 8'h00;
			bit_rate_select       <= 8'h00;
			uart_control          <= 8'h00;
			uart_multiplex        <= 8'h00;
			timing_chain_index    <= 8'h00;
			r0                    <= 8'h00;
			r1                    <= 8'h00;
			upper_byte_for_r0     <= 8'h00;
			upper_byte_for_r1     <= 8'h00;
			dm_req                <= 1'b0;
			dm_we                 <= 1'b0;
			dm_addr               <= 16'h0000;
			dm_wdata              <= 16'h0000;
		end else begin
			case (state)
			ST_IDLE: begin
				// parked: keep the opcode at pc on the program bus
				pm_addr <= pc;
				if (run)
					state <= ST_EXEC;
			end
			ST_EXEC: begin
				// opcode is on pm_data; two-byte ops fetch their operand next
				cur_op <= op;
				if (is_jump || op == `VCMB_OP_LD_IMM) begin
					take    <= jump_cond;
					pm_addr <= pc_one;
					state   <= ST_OPER;
				end else if (op == `VCMB_OP_TBL_PAGE) begin
					// borrow pm_addr for the table byte; pc itself is kept
					pm_addr <= {pc[12:8], acc};
					state   <= ST_TABLE;
				end else if (op == `VCMB_OP_TBL_PAGE3) begin
					pm_addr <= {pc[12:11], `VCMB_PAGE3_BITS, acc};
					state   <= ST_TABLE;
				end else if (dm_start) begin
					// request and its qualifiers stand until the ack
					dm_req   <= 1'b1;
					dm_we    <= dm_write;
					dm_addr  <= dm_target;
					dm_wdata <= acc_pair;
					state    <= ST_DMEM;
				end else begin
					// one-byte moves retire in this cycle
					pc      <= pc_one;
					pm_addr <= pc_one;
					state   <= run ? ST_EXEC : ST_IDLE;
					// pair loads also refresh the upper flag
					case (op)
						`VCMB_OP_RD_TPP: begin
							{upper_accumulator, acc} <= text_position_pointer;
							upper_acc_flag <= (text_position_pointer[15:8] != 8'h00);
						end
						`VCMB_OP_RD_ORG: begin
							{upper_accumulator, acc} <= screen_origin;
							upper_acc_flag <= (screen_origin[15:8] != 8'h00);
						end
						`VCMB_OP_RD_HORIZONTAL_LIGHTPEN_LATCH:   acc <= {1'b0, horizontal_lightpen_latch};
						`VCMB_OP_RD_VERTICAL_LIGHTPEN_LATCH:   acc <= {3'h0, vertical_lightpen_latch};
						`VCMB_OP_RD_UCOND:  acc <= {2'h3, uart_condition_latch};
						`VCMB_OP_RD_INTREG: acc <= interrupt_register;
						`VCMB_OP_WR_IEN:    interrupt_enable <= acc;
						`VCMB_OP_WR_UPPER: begin
							upper_accumulator <= acc;
							upper_acc_flag    <= (acc != 8'h00);
						end
						`VCMB_OP_RD_UPPER:  acc <= upper_accumulator;
						`VCMB_OP_WR_START:  display_ram_start <= acc_pair;
						`VCMB_OP_WR_LAST:   display_ram_last <= acc_pair;
						`VCMB_OP_WR_SLINE:  status_line_address <= acc_pair;
						`VCMB_OP_WR_ORG:    screen_origin <= acc_pair;
						`VCMB_OP_WR_TPP:    text_position_pointer <= acc_pair;
						`VCMB_OP_WR_TCIDX:  timing_chain_index <= acc;
						`VCMB_OP_WR_TCIND:  timing_chain_index <= timing_chain_index + 8'h01;
						`VCMB_OP_RD_STATW:  acc <= program_status_word;
						`VCMB_OP_WR_STATW:  program_status_word <= acc;
						`VCMB_OP_PAIR_A_R0: begin
							{upper_accumulator, acc} <= {upper_byte_for_r0, r0};
							upper_acc_flag <= (upper_byte_for_r0 != 8'h00);
						end
						`VCMB_OP_PAIR_A_R1: begin
							{upper_accumulator, acc} <= {upper_byte_for_r1, r1};
							upper_acc_flag <= (upper_byte_for_r1 != 8'h00);
						end
						`VCMB_OP_PAIR_R0_A: {upper_byte_for_r0, r0} <= acc_pair;
						`VCMB_OP_PAIR_R1_A: {upper_byte_for_r1, r1} <= acc_pair;
						`VCMB_OP_RD_TIMER:  acc <= timer_value;
						`VCMB_OP_WR_TIMER:  timer_value <= acc;
						`VCMB_OP_WR_PRESC:  uart_prescaler <= acc;
						`VCMB_OP_WR_RATE:   bit_rate_select <= acc;
						`VCMB_OP_WR_UCTL:   uart_control <= acc;
						`VCMB_OP_WR_UMUX:   uart_multiplex <= acc;
						default: ;
					endcase
				end
			end
			ST_OPER: begin
				// operand byte is on pm_data now
				state <= run ? ST_EXEC : ST_IDLE;
				if (cur_op == `VCMB_OP_LD_IMM) begin
					acc     <= pm_data;
					pc      <= pc_two;
					pm_addr <= pc_two;
				end else if (take) begin
					// taken: only the low byte of pc changes
					pc      <= {pc[12:8], pm_data};
					pm_addr <= {pc[12:8], pm_data};
				end else begin
					// not taken: step over the operand byte
					pc      <= pc_two;
					pm_addr <= pc_two;
				end
			end
			ST_TABLE: begin
				// table byte lands in acc; pc resumes at old value plus one
				acc     <= pm_data;
				pc      <= pc_one;
				pm_addr <= pc_one;
				state   <= run ? ST_EXEC : ST_IDLE;
			end
			ST_DMEM: begin
				// read word is valid only in the ack cycle
				if (dm_ack) begin
					dm_req  <= 1'b0;
					dm_we   <= 1'b0;
					pc      <= pc_one;
					pm_addr <= pc_one;
					state   <= run ? ST_EXEC : ST_IDLE;
					if (!dm_we) begin
						{upper_accumulator, acc} <= dm_rdata;
						upper_acc_flag <= (dm_rdata[15:8] != 8'h00);
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timing chain registers
	// written only through the index; read back on the register port

	genvar gi;
	generate
		for (gi = 0; gi < `VCMB_TC_DEPTH; gi = gi + 1) begin : g_tc
			// entry number at the width of the index field
			localparam [3:0] TC_SEL = gi;
			always @(posedge mclk) begin
				if (!rst_n)
					tc_q[gi] <= 8'h00;
				else if (in_exec && op == `VCMB_OP_WR_TCIND &&
						timing_chain_index[3:0] == TC_SEL)
					tc_q[gi] <= acc;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// register port

	always @(posedge mclk) begin
		if (!rst_n) begin
			run            <= 1'b0;
			user_flag_zero <= 1'b0;
			user_flag_one  <= 1'b0;
		end else if (reg_wr && reg_addr == `VCMB_RA_CTRL) begin
			// writes elsewhere in the map are ignored
			run            <= reg_wdata[`VCMB_CTRL_RUN];
			user_flag_zero <= reg_wdata[`VCMB_CTRL_UF0];
			user_flag_one  <= reg_wdata[`VCMB_CTRL_UF1];
		end
	end

	always @(posedge mclk) begin
		// answer stands one cycle after the read strobe, zero otherwise
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (!reg_rd)
			reg_rdata <= 8'h00;
		// upper half of the map reads the timing chain
		else if (reg_addr[4] == `VCMB_RA_TC_BASE)
			reg_rdata <= tc_q[reg_addr[3:0]];
		else begin
			case (reg_addr)
				`VCMB_RA_CTRL:   reg_rdata <= {5'h00, user_flag_one, user_flag_zero, run};
				`VCMB_RA_STATUS: reg_rdata <= {3'h0, state};
				`VCMB_RA_PC_LO:  reg_rdata <= pc[7:0];
				`VCMB_RA_PC_HI:  reg_rdata <= {3'h0, pc[12:8]};
				`VCMB_RA_ACC:    reg_rdata <= acc;
				`VCMB_RA_UPPER:  reg_rdata <= upper_accumulator;
				`VCMB_RA_R0:     reg_rdata <= r0;
				`VCMB_RA_R1:     reg_rdata <= r1;
				`VCMB_RA_RA:     reg_rdata <= upper_byte_for_r0;
				`VCMB_RA_RB:     reg_rdata <= upper_byte_for_r1;
				default:         reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule // vcmb_move_branch

`default_nettype wire

/* File: vcmb_move_branch_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module vcmb_chk (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        dm_req,
	input wire logic        dm_we,
	input wire logic [15:0] dm_addr,
	input wire logic [15:0] dm_wdata,
	input wire logic [15:0] dm_rdata,
	input wire logic        dm_ack,
	input wire logic        timer_event,
	input wire logic        timer_flag,
	input wire logic [12:0] pc,
	input wire logic [7:0]  acc,
	input wire logic [7:0]  upper_accumulator,
	input wire logic        upper_acc_flag,
	input wire logic [7:0]  interrupt_enable,
	input wire logic [15:0] display_ram_start,
	input wire logic [7:0]  uart_prescaler,
	input wire logic [7:0]  timing_chain_index
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence dm_wait;
		dm_req && !dm_ack;
	endsequence
	sequence dm_done;
		dm_req && dm_ack;
	endsequence
	a_dm_hold_req: assert property (dm_wait |=>
		dm_req && $stable(dm_addr) && $stable(dm_we) && $stable(dm_wdata))
		else $error("display request changed before ack");
	a_dm_drop_req: assert property (dm_done |=> !dm_req)
		else $error("display request held after ack");
	a_dm_read_word: assert property (dm_done ##0 !dm_we |=>
		{upper_accumulator, acc} == $past(dm_rdata))
		else $error("display read word not loaded into pair");
	a_dm_write_word: assert property (dm_req && dm_we |->
		dm_wdata == {upper_accumulator, acc})
		else $error("display write word differs from pair");
	a_timer_set: assert property (timer_event |=> timer_flag)
		else $error("timer flag not set by event");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read answer");
	a_tc_index_step: assert property ($changed(timing_chain_index) |->
		timing_chain_index == $past(timing_chain_index) + 8'h01
		|| timing_chain_index == $past(acc))
		else $error("timing chain index moved wrongly");
	a_start_from_pair: assert property ($changed(display_ram_start) |->
		display_ram_start == $past({upper_accumulator, acc}))
		else $error("display start not loaded from pair");
	a_ien_from_acc: assert property ($changed(interrupt_enable) |->
		interrupt_enable == $past(acc))
		else $error("interrupt enable not loaded from acc");
	a_presc_from_acc: assert property ($changed(uart_prescaler) |->
		uart_prescaler == $past(acc))
		else $error("prescaler not loaded from acc");
	a_upper_flag: assert property ($changed(upper_accumulator) |->
		upper_acc_flag == (upper_accumulator != 8'h00))
		else $error("upper flag does not follow upper byte");
	a_page_kept: assert property ($changed(pc) |->
		pc[12:8] == $past(pc[12:8]) || pc == $past(pc) + 13'h0001)
		else $error("jump changed upper counter bits");
endmodule // vcmb_chk

bind vcmb_move_branch vcmb_chk chk_u (.mclk(mclk), .rst_n(rst_n), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr),
	.dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_ack(dm_ack), .timer_event(timer_event),
	.timer_flag(timer_flag), .pc(pc), .acc(acc), .upper_accumulator(upper_accumulator),
	.upper_acc_flag(upper_acc_flag), .interrupt_enable(interrupt_enable),
	.display_ram_start(display_ram_start), .uart_prescaler(uart_prescaler),
	.timing_chain_index(timing_chain_index));
`default_nettype wire

/* File: vcmb_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module vcmb_mem_model (
	input  wire logic        mclk,
	input  wire logic [12:0] pm_addr,
	output wire logic [7:0]  pm_data,
	input  wire logic        dm_req,
	input  wire logic        dm_we,
	input  wire logic [15:0] dm_addr,
	input  wire logic [15:0] dm_wdata,
	output var  logic [15:0] dm_rdata,
	output var  logic        dm_ack,
	input  wire logic [3:0]  ack_wait
);
	logic [7:0]  pm [0:8191];
	logic [15:0] dm [0:65535];
	logic [3:0]  wait_cnt;
	initial begin
		for (int i = 0; i < 8192; i++) begin
			pm[i] = 8'h00;
		end
		wait_cnt = 4'h0;
		dm_rdata = 16'h0000;
		dm_ack = 1'b0;
	end
	assign pm_data = pm[pm_addr];
	// read word only valid with ack; toggles otherwise
	always @(posedge mclk) begin
		dm_ack <= 1'b0;
		dm_rdata <= ~dm_rdata;
		if (dm_req && !dm_ack) begin
			if (wait_cnt == ack_wait) begin
				dm_ack <= 1'b1;
				wait_cnt <= 4'h0;
				if (dm_we)
					dm[dm_addr] <= dm_wdata;
				else
					dm_rdata <= dm[dm_addr];
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule // vcmb_mem_model
`default_nettype wire

/* File: tb_vcmb_move_branch.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_vcmb_move_branch;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  reg_addr = 5'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        external_interrupt_pin = 1'b0;
	logic        timer_event = 1'b0;
	logic [3:0]  ack_wait = 4'h0;
	logic [7:0]  rd_val;
	int          err_count = 0;
	int          check_count = 0;
	wire  [12:0] pm_addr, pc;
	wire         dm_req, dm_we, dm_ack, upper_acc_flag, timer_flag;
	wire  [15:0] dm_addr, dm_wdata, dm_rdata, display_ram_start, display_ram_last;
	wire  [15:0] status_line_address, screen_origin, text_position_pointer;
	wire  [7:0]  reg_rdata, pm_data, acc, upper_accumulator, timer_value, program_status_word;
	wire  [7:0]  interrupt_enable, uart_prescaler, bit_rate_select, uart_control;
	wire  [7:0]  uart_multiplex, timing_chain_index;
	localparam logic [623:0] PROG = {8'h23, 8'h00, 8'hC6, 8'h06, 8'h23, 8'hFF, 8'hD6, 8'h04,
		8'h16, 8'h0C, 8'hC6, 8'h0A, 8'h06, 8'h10, 8'hC6, 8'h0E, 8'h86, 8'h14, 8'hC6, 8'h12,
		8'h66, 8'h12, 8'hA6, 8'h16, 8'h06, 8'h12, 8'hB6, 8'h1E, 8'hC6, 8'h1C, 8'h16, 8'h12,
		8'h23, 8'h5A, 8'hC2, 8'h23, 8'h34, 8'h0D, 8'h0C, 8'h0E, 8'h8A, 8'h8B, 8'h82, 8'h22,
		8'h02, 8'h01, 8'h33, 8'h62, 8'hD7, 8'h87, 8'hB7, 8'h88, 8'h3F, 8'h3E, 8'h9C, 8'h8C,
		8'h9D, 8'hE2, 8'h80, 8'h42, 8'hB3, 8'h23, 8'h10, 8'hF3, 8'h98, 8'h89, 8'h91, 8'hC7,
		8'h8D, 8'h9A, 8'h90, 8'h9B, 8'h91, 8'h99, 8'h23, 8'h00, 8'hC6, 8'h4C};

	always #5 mclk = ~mclk;

	vcmb_move_branch dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req), .dm_we(dm_we),
		.dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_ack(dm_ack),
		.external_interrupt_pin(external_interrupt_pin), .timer_event(timer_event),
		.horizontal_lightpen_latch(7'h55), .vertical_lightpen_latch(5'h0A),
		.uart_condition_latch(6'h05), .interrupt_register(8'hA5), .pc(pc), .acc(acc),
		.upper_accumulator(upper_accumulator), .upper_acc_flag(upper_acc_flag),
		.timer_flag(timer_flag), .timer_value(timer_value),
		.program_status_word(program_status_word), .interrupt_enable(interrupt_enable),
		.display_ram_start(display_ram_start), .display_ram_last(display_ram_last),
		.status_line_address(status_line_address), .screen_origin(screen_origin),
		.text_position_pointer(text_position_pointer), .uart_prescaler(uart_prescaler),
		.bit_rate_select(bit_rate_select), .uart_control(uart_control),
		.uart_multiplex(uart_multiplex), .timing_chain_index(timing_chain_index));

	vcmb_mem_model mem_u (.mclk(mclk), .pm_addr(pm_addr), .pm_data(pm_data),
		.dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
		.dm_rdata(dm_rdata), .dm_ack(dm_ack), .ack_wait(ack_wait));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask

	// skipped branch slots hold loops (the one at 0004 loops back through 0006), so a wrong path times out here
	task automatic wait_pc(input logic [12:0] a);
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (pc !== a && n < 400);
		if (n >= 400) begin
			err_count++;
			$display("[ERR] %0t pc never reached %h", $time, a);
			wrap_up();
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		// load after time zero so the model's own clearing cannot overwrite it
		repeat (16) @(posedge mclk);
		for (int i = 0; i < 78; i++) begin
			mem_u.pm[i] = PROG[8*(77-i) +: 8];
		end
		mem_u.pm[13'h0310] = 8'hC3;
		mem_u.dm[16'h5A34] = 16'hBEEF;
		rst_n <= 1'b1;
		@(negedge mclk);
		chk(pc, 16'h0000);
		chk(display_ram_start, 16'h0000);
		@(posedge mclk);
		timer_event <= 1'b1;
		@(posedge mclk);
		timer_event <= 1'b0;
		reg_write(5'h00, 8'h05);
		wait_pc(13'h0008);
		chk(acc, 16'h0000);
		wait_pc(13'h0016);
		chk(timer_flag, 1'b0);
		@(posedge mclk);
		timer_event <= 1'b1;
		external_interrupt_pin <= 1'b1;
		@(posedge mclk);
		timer_event <= 1'b0;
		wait_pc(13'h0020);
		chk(timer_flag, 1'b0);
		wait_pc(13'h0025);
		chk({upper_accumulator, acc}, 16'h5A34);
		chk(upper_acc_flag, 1'b1);
		wait_pc(13'h002A);
		chk(display_ram_start, 16'h5A34);
		chk(display_ram_last, 16'h5A34);
		chk(status_line_address, 16'h5A34);
		chk(screen_origin, 16'h5A34);
		chk(text_position_pointer, 16'h5A34);
		wait_pc(13'h0034);
		chk(interrupt_enable, 16'h0034);
		chk(uart_prescaler, 16'h0034);
		chk(bit_rate_select, 16'h0034);
		chk(uart_control, 16'h0034);
		chk(uart_multiplex, 16'h0034);
		chk(timer_value, 16'h0034);
		chk(program_status_word, 16'h0034);
		chk(timing_chain_index, 16'h0035);
		wait_pc(13'h0035);
		chk(acc, 16'h0055);
		wait_pc(13'h0036);
		chk(acc, 16'h000A);
		wait_pc(13'h0037);
		chk(acc, 16'h00C5);
		wait_pc(13'h0038);
		chk(acc, 16'h00A5);
		wait_pc(13'h0039);
		chk({upper_accumulator, acc}, 16'hBEEF);
		ack_wait <= 4'h3;
		wait_pc(13'h003B);
		chk(mem_u.dm[16'h5A34], 16'hBEBE);
		wait_pc(13'h003C);
		chk(acc, 16'h0034);
		wait_pc(13'h003D);
		chk(acc, 16'h003F);
		wait_pc(13'h0040);
		chk(acc, 16'h00C3);
		wait_pc(13'h0041);
		chk({upper_accumulator, acc}, 16'h5A34);
		wait_pc(13'h0043);
		chk({upper_accumulator, acc}, 16'hBEBE);
		wait_pc(13'h0044);
		chk(acc, 16'h0034);
		wait_pc(13'h0045);
		chk(mem_u.dm[16'h5A34], 16'hBE34);
		wait_pc(13'h0046);
		chk({upper_accumulator, acc}, 16'h5A34);
		wait_pc(13'h0047);
		chk({upper_accumulator, acc}, 16'hBE34);
		wait_pc(13'h0048);
		chk({upper_accumulator, acc}, 16'h5A34);
		wait_pc(13'h0049);
		chk({upper_accumulator, acc}, 16'hBE34);
		wait_pc(13'h004A);
		chk({upper_accumulator, acc}, 16'h5A34);
		wait_pc(13'h004C);
		repeat (4) @(posedge mclk);
		chk(pc, 16'h004C);
		reg_read(5'h06, rd_val);
		chk(rd_val, 16'h0034);
		reg_read(5'h08, rd_val);
		chk(rd_val, 16'h005A);
		reg_read(5'h07, rd_val);
		chk(rd_val, 16'h0034);
		reg_read(5'h09, rd_val);
		chk(rd_val, 16'h005A);
		reg_read(5'h00, rd_val);
		chk(rd_val, 16'h0005);
		reg_read(5'h14, rd_val);
		chk(rd_val, 16'h0034);
		reg_read(5'h0A, rd_val);
		chk(rd_val, 16'h0000);
		reg_write(5'h04, 8'hFF);
		reg_read(5'h04, rd_val);
		chk(rd_val, 16'h0000);
		wrap_up();
	end
endmodule // tb_vcmb_move_branch
`default_nettype wire
